//--- rtl/diag_seq.sv
// Notes on behaviour
// - Keyboard test shows the name of the most recently pressed key.
// - Keyboard test ends only on reset key; shows reset one second, then measures.
// - In keyboard test diag and step keys are names; arrows report scale, smooth.
// - Display test alternates all lit and all blank, never overload indication.
// - Step-up saturates at 96; modes above need number entry and enter key, or a bus write.
// - Filter-adjust ignores all keys; only power-down leaves, diag number becomes 1.
// - Keyboard lockout entry shows lock message one second, then ignores keys.
// - Under keyboard lockout any key briefly shows the lock message again.
// - Standby power-up under keyboard lockout shows message two seconds, diag 1.
// - Keyboard lockout ends by mains removal or keys 7, 4, 0, reset.
// - Display lockout blanks annunciators, hides overload, shows constant message.
// - Standby power-up under display lockout measures with message only, diag 1.
// - Power-up lights everything three seconds, then bus address, then measures.
// - Power-up steps run in fixed order ending with diag 1 and measurement.
// - Self-test subset runs supply through low-frequency 1 megohm in fixed order.
// - Failed power-up test holds until reset key, then continues with next test.
// - Unreachable bus interface board shows a not-installed message.
// - Self check key runs the subset once with its own messages.
// - Passed self check shows pass three seconds, returns to previous mode.
// - In self check, supply, timebase, interpolator failures get named messages; others generic.
// - IF verification switches off microwave power, keeps IF path, counts test signal.
// - IF override modes ignore software or both flags and display the IF.
// - Hardware IF flag disabled means IF assumed in band, measuring continues.
// - Bus verification commands the interface board start-up tests, reports result.
`timescale 1ns/1ps
`default_nettype none
module diag_seq
	import diag_seq_pkg::*;
#(
	parameter logic [31:0] ONE_S   = 32'(ONE_S_CYC),
	parameter logic [31:0] TWO_S   = 32'(TWO_S_CYC),
	parameter logic [31:0] THREE_S = 32'(THREE_S_CYC),
	parameter logic [31:0] BRIEF   = 32'(BRIEF_CYC),
	parameter logic [31:0] BLINK   = 32'(BLINK_CYC)
) (
	input  wire logic         clk,
	input  wire logic         rstn,
	input  wire logic         wb_cyc_i,
	input  wire logic         wb_stb_i,
	input  wire logic         wb_we_i,
	input  wire logic [3:0]   wb_adr_i,
	input  wire logic [3:0]   wb_sel_i,
	input  wire logic [31:0]  wb_dat_i,
	output logic      [31:0]  wb_dat_o,
	output logic              wb_ack_o,
	input  wire key_type      key,
	input  wire logic         standby_wake,
	input  wire test_ans_type ans,
	output test_cmd_type      cmd,
	output disp_type          disp,
	output logic              hw_if_flag_off,
	output logic              sw_if_flag_off
);

	state_type    state_q;
	run_type      run_q;
	msg_type      msg_q;
	logic [4:0]   step_q;
	logic [31:0]  tmr_q;
	logic [6:0]   diag_q;
	logic [6:0]   entry_q;
	logic [4:0]   name_q;
	logic [1:0]   match_q;
	logic         entry_mode_q;
	logic         kb_lock_q;
	logic         disp_lock_q;
	logic         from_standby_state_q;
	logic         fail_seen_q;
	logic         blink_q;
	logic         show_if_q;
	logic         act_go;
	logic [6:0]   act_num;
	logic         go_next;
	logic         exit_seq;
	logic         keys_live;
	logic [4:0]   last_step;
	logic         wb_req;
	disp_type     disp_d;

	function automatic logic [6:0] step_up(input logic [6:0] n);
		step_up = (n >= DIAG_STEP_MAX) ? DIAG_STEP_MAX : n + 7'h01;
	endfunction

	function automatic msg_type fail_msg(input run_type r, input logic [4:0] s);
		if (r != RUN_SELF) begin
			fail_msg = MSG_FAIL;
		end else if (s == STEP_SUPPLY) begin
			fail_msg = MSG_FAIL_POWER;
		end else if (s == STEP_TIMEBASE) begin
			fail_msg = MSG_FAIL_TIMEBASE;
		end else if (s == STEP_INTERP) begin
			fail_msg = MSG_FAIL_INTERP;
		end else begin
			fail_msg = MSG_FAIL_SELF;
		end
	endfunction

	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign keys_live = (state_q == ST_MEASURE) && !kb_lock_q;
	assign exit_seq = key.valid && key.code == KEY_RESET && match_q == 2'd3;
	assign last_step = (run_q == RUN_SELF) ? STEP_SUBSET_LAST : STEP_PWR_LAST;

	// Step keys and numeric entry both funnel into one activation request.
	always_comb begin
		act_go = 1'b0;
		act_num = diag_q;
		if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == DIAG_OFS && keys_live) begin
			act_go = 1'b1;
			act_num = wb_dat_i[6:0];
		end else if (keys_live && key.valid) begin
			if (key.code == KEY_ENTER && entry_mode_q) begin
				act_go = 1'b1;
				act_num = entry_q;
			end else if (key.code == KEY_STEP_UP) begin
				act_go = 1'b1;
				act_num = step_up(diag_q);
			end else if (key.code == KEY_STEP_DOWN) begin
				act_go = 1'b1;
				act_num = (diag_q == 7'h00) ? 7'h00 : diag_q - 7'h01;
			end
		end
	end

	always_comb begin
		go_next = 1'b0;
		if (run_q != RUN_SINGLE) begin
			if (state_q == ST_RUN && ans.done && ans.pass) begin
				go_next = !(step_q == STEP_BUS_IF && ans.bus_if_absent);
			end else if (state_q == ST_HOLD && key.valid && key.code == KEY_RESET) begin
				go_next = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			entry_mode_q <= 1'b0;
			entry_q <= 7'h00;
		end else if (keys_live && key.valid) begin
			if (key.code == KEY_DIAG) begin
				entry_mode_q <= 1'b1;
				entry_q <= 7'h00;
			end else if (key.code <= 5'h09) begin
				entry_q <= 7'((entry_q % 7'd10) * 7'd10 + 7'(key.code));
			end else begin
				entry_mode_q <= 1'b0;
			end
		end
	end

	// Either lockout is left by 7, 4, 0, reset; a stray key restarts the match.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			match_q <= 2'd0;
		end else if (key.valid && (kb_lock_q || disp_lock_q)) begin
			if (match_q == 2'd0 && key.code == KEY_SEVEN) begin
				match_q <= 2'd1;
			end else if (match_q == 2'd1 && key.code == KEY_FOUR) begin
				match_q <= 2'd2;
			end else if (match_q == 2'd2 && key.code == KEY_ZERO) begin
				match_q <= 2'd3;
			end else begin
				match_q <= (key.code == KEY_SEVEN) ? 2'd1 : 2'd0;
			end
		end
	end

	// Mains removal is rstn and clears both lockouts; standby_wake keeps them.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= ST_LIT;
			run_q <= RUN_POWER;
			msg_q <= MSG_MEASURE;
			step_q <= 5'h00;
			tmr_q <= THREE_S;
			diag_q <= DIAG_RESET;
			name_q <= 5'h00;
			kb_lock_q <= 1'b0;
			disp_lock_q <= 1'b0;
			from_standby_state_q <= 1'b0;
			fail_seen_q <= 1'b0;
			blink_q <= 1'b0;
			show_if_q <= 1'b0;
			hw_if_flag_off <= 1'b0;
			sw_if_flag_off <= 1'b0;
			cmd <= '0;
		end else begin
			cmd.start <= 1'b0;
			if (tmr_q != 32'h0) begin
				tmr_q <= tmr_q - 32'h1;
			end
			if (standby_wake) begin
				state_q <= ST_LIT;
				run_q <= RUN_POWER;
				from_standby_state_q <= 1'b1;
				tmr_q <= THREE_S;
			end else if (go_next) begin
				if (step_q == last_step) begin
					if (run_q == RUN_SELF) begin
						state_q <= fail_seen_q ? ST_MEASURE : ST_PASS;
						tmr_q <= THREE_S;
					end else begin
						diag_q <= DIAG_RESET;
						state_q <= (kb_lock_q && from_standby_state_q) ? ST_MSG : ST_MEASURE;
						msg_q <= MSG_LOCK_KB;
						tmr_q <= TWO_S;
					end
				end else begin
					step_q <= step_q + 5'h01;
					cmd.id <= step_q + 5'h01;
					cmd.start <= 1'b1;
					state_q <= ST_RUN;
				end
			end else begin
				case (state_q)
					ST_LIT: begin
						if (tmr_q == 32'h0) begin
							step_q <= STEP_FIRST;
							cmd.id <= STEP_FIRST;
							cmd.start <= 1'b1;
							state_q <= ST_RUN;
						end
					end
					ST_RUN: begin
						if (ans.done) begin
							state_q <= ST_HOLD;
							fail_seen_q <= fail_seen_q | !ans.pass;
							msg_q <= ans.pass ? MSG_PASS : fail_msg(run_q, step_q);
							if (step_q == STEP_BUS_IF && ans.bus_if_absent) begin
								msg_q <= MSG_NOT_INSTALLED;
							end
						end
					end
					ST_HOLD: begin
						if (key.valid && key.code == KEY_RESET) begin
							state_q <= ST_MEASURE;
							cmd.mw_power_off <= 1'b0;
						end
					end
					ST_MSG, ST_PASS: begin
						// The exit sequence often ends while a key has recalled the lock message.
						if (exit_seq) begin
							kb_lock_q <= 1'b0;
							disp_lock_q <= 1'b0;
						end
						if (tmr_q == 32'h0) begin
							state_q <= ST_MEASURE;
						end
					end
					ST_KEYTEST: begin
						if (key.valid && key.code == KEY_RESET) begin
							state_q <= ST_MSG;
							msg_q <= MSG_RESET;
							tmr_q <= ONE_S;
						end else if (key.valid) begin
							msg_q <= MSG_KEY_NAME;
							name_q <= (key.code == KEY_STEP_UP) ? KEY_SCALE :
								(key.code == KEY_STEP_DOWN) ? KEY_SMOOTH : key.code;
						end
					end
					ST_DISPTEST: begin
						if (key.valid && key.code == KEY_RESET) begin
							state_q <= ST_MEASURE;
						end else if (tmr_q == 32'h0) begin
							blink_q <= !blink_q;
							tmr_q <= BLINK;
						end
					end
					ST_FILTER: begin
						state_q <= ST_FILTER;
					end
					ST_MEASURE: begin
						if (exit_seq) begin
							kb_lock_q <= 1'b0;
							disp_lock_q <= 1'b0;
						end else if (kb_lock_q && key.valid) begin
							state_q <= ST_MSG;
							msg_q <= MSG_LOCK_KB;
							tmr_q <= BRIEF;
						end else if (key.valid && key.code == KEY_SELF) begin
							run_q <= RUN_SELF;
							fail_seen_q <= 1'b0;
							step_q <= STEP_SUPPLY;
							cmd.id <= STEP_SUPPLY;
							cmd.start <= 1'b1;
							state_q <= ST_RUN;
						end else if (key.valid && key.code == KEY_RESET) begin
							hw_if_flag_off <= 1'b0;
							sw_if_flag_off <= 1'b0;
							show_if_q <= 1'b0;
						end else if (act_go) begin
							diag_q <= act_num;
							hw_if_flag_off <= act_num == DIAG_IF_HW || act_num == DIAG_IF_BOTH;
							sw_if_flag_off <= act_num == DIAG_IF_SW || act_num == DIAG_IF_BOTH;
							show_if_q <= act_num == DIAG_IF_SW || act_num == DIAG_IF_BOTH;
							case (act_num)
								DIAG_KEY_TEST: begin
									state_q <= ST_KEYTEST;
									msg_q <= MSG_KEY_TEST;
								end
								DIAG_DISP_TEST: begin
									state_q <= ST_DISPTEST;
									tmr_q <= BLINK;
								end
								DIAG_FILTER: begin
									state_q <= ST_FILTER;
								end
								DIAG_KB_LOCK: begin
									kb_lock_q <= 1'b1;
									state_q <= ST_MSG;
									msg_q <= MSG_LOCK_KB;
									tmr_q <= ONE_S;
								end
								DIAG_DISP_LOCK: begin
									disp_lock_q <= 1'b1;
								end
								DIAG_IF_VERIFY, DIAG_BUS_VERIFY: begin
									run_q <= RUN_SINGLE;
									step_q <= (act_num == DIAG_IF_VERIFY) ? STEP_IF_VERIFY : STEP_BUS_IF;
									cmd.id <= (act_num == DIAG_IF_VERIFY) ? STEP_IF_VERIFY : STEP_BUS_IF;
									cmd.mw_power_off <= act_num == DIAG_IF_VERIFY;
									cmd.start <= 1'b1;
									state_q <= ST_RUN;
								end
								default: begin
									state_q <= ST_MEASURE;
								end
							endcase
						end
					end
					default: begin
						state_q <= ST_MEASURE;
					end
				endcase
			end
		end
	end

	always_comb begin
		disp_d = '{msg: MSG_MEASURE, arg: diag_q, all_lit: 1'b0, annun_en: 1'b1, overload_indication_en: 1'b1};
		case (state_q)
			ST_LIT: begin
				disp_d.msg = MSG_ALL_LIT;
				disp_d.all_lit = 1'b1;
			end
			ST_RUN: begin
				disp_d.msg = (run_q == RUN_POWER && step_q >= STEP_BUS_IF) ? MSG_ADDR : MSG_MEASURE;
				disp_d.arg = {2'b00, step_q};
			end
			ST_HOLD, ST_MSG: begin
				disp_d.msg = msg_q;
				disp_d.arg = {2'b00, step_q};
				disp_d.overload_indication_en = msg_q != MSG_LOCK_KB;
			end
			ST_PASS: begin
				disp_d.msg = MSG_PASS_SELF;
			end
			ST_KEYTEST: begin
				disp_d.msg = msg_q;
				disp_d.arg = {2'b00, name_q};
			end
			ST_DISPTEST: begin
				disp_d.msg = blink_q ? MSG_BLANK : MSG_ALL_LIT;
				disp_d.all_lit = !blink_q;
				disp_d.annun_en = !blink_q;
				disp_d.overload_indication_en = 1'b0;
			end
			ST_FILTER: begin
				disp_d.msg = MSG_FILTER;
			end
			default: begin
				disp_d.msg = show_if_q ? MSG_IF_VALUE : MSG_MEASURE;
			end
		endcase
		if (disp_lock_q && state_q == ST_MEASURE) begin
			disp_d.msg = MSG_LOCK_DISP;
			disp_d.annun_en = 1'b0;
			disp_d.overload_indication_en = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			disp <= '{msg: MSG_ALL_LIT, arg: 7'h00, all_lit: 1'b1, annun_en: 1'b1, overload_indication_en: 1'b0};
		end else begin
			disp <= disp_d;
		end
	end

	// Single-cycle classic slave: ack one edge after the strobe, unmapped reads zero.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= wb_req;
			wb_dat_o <= 32'h0;
			if (wb_req && !wb_we_i && wb_adr_i == DIAG_OFS) begin
				wb_dat_o <= {25'h0, diag_q};
			end else if (wb_req && !wb_we_i && wb_adr_i == STATUS_OFS) begin
				wb_dat_o <= {11'h0, step_q, 4'(state_q), 4'h0, show_if_q, sw_if_flag_off,
					hw_if_flag_off, disp_lock_q, kb_lock_q, fail_seen_q, 2'(run_q)};
			end
		end
	end

	property p_step_sat;
		@(posedge clk) disable iff (!rstn)
		keys_live && key.valid && key.code == KEY_STEP_UP && diag_q == DIAG_STEP_MAX
			&& !wb_req && !standby_wake |=> diag_q == DIAG_STEP_MAX;
	endproperty
	a_step_sat: assert property (p_step_sat) else $error("step-up passed 96");

	property p_filter_stays;
		@(posedge clk) disable iff (!rstn)
		state_q == ST_FILTER && !standby_wake |=> state_q == ST_FILTER && disp.msg == MSG_FILTER;
	endproperty
	a_filter_stays: assert property (p_filter_stays) else $error("filter mode left");

	property p_disptest_no_overload_indication;
		@(posedge clk) disable iff (!rstn)
		state_q == ST_DISPTEST |=> !disp.overload_indication_en;
	endproperty
	a_disptest_no_overload_indication: assert property (p_disptest_no_overload_indication) else $error("overload_indication in test");

	property p_exit_lock;
		@(posedge clk) disable iff (!rstn)
		state_q == ST_MEASURE && exit_seq && !standby_wake |=> !kb_lock_q && !disp_lock_q;
	endproperty
	a_exit_lock: assert property (p_exit_lock) else $error("lockout not cleared");

	property p_disp_lock;
		@(posedge clk) disable iff (!rstn)
		disp_lock_q && state_q == ST_MEASURE |=> disp.msg == MSG_LOCK_DISP && !disp.annun_en;
	endproperty
	a_disp_lock: assert property (p_disp_lock) else $error("display lockout shown wrong");

	property p_hold_fail;
		@(posedge clk) disable iff (!rstn)
		state_q == ST_HOLD && !(key.valid && key.code == KEY_RESET) && !standby_wake
			|=> state_q == ST_HOLD;
	endproperty
	a_hold_fail: assert property (p_hold_fail) else $error("failure hold left");

	property p_not_installed;
		@(posedge clk) disable iff (!rstn)
		state_q == ST_RUN && step_q == STEP_BUS_IF && ans.done && ans.bus_if_absent
			&& !standby_wake |=> ##1 disp.msg == MSG_NOT_INSTALLED;
	endproperty
	a_not_installed: assert property (p_not_installed) else $error("no not-installed");

	property p_lit_first;
		@(posedge clk) disable iff (!rstn)
		$rose(state_q == ST_LIT) |=> disp.all_lit [*2];
	endproperty
	a_lit_first: assert property (p_lit_first) else $error("power-up not all lit");

	property p_self_start;
		@(posedge clk) disable iff (!rstn)
		keys_live && key.valid && key.code == KEY_SELF && !exit_seq && !standby_wake
			|=> cmd.start && cmd.id == STEP_SUPPLY && run_q == RUN_SELF;
	endproperty
	a_self_start: assert property (p_self_start) else $error("self check not started");

	c_self_pass: cover property (@(posedge clk) disable iff (!rstn) state_q == ST_PASS);
	c_kb_lock: cover property (@(posedge clk) disable iff (!rstn) $fell(kb_lock_q));
	c_keytest: cover property (@(posedge clk) disable iff (!rstn) state_q == ST_KEYTEST);

endmodule
`default_nettype wire

//--- rtl/diag_seq_pkg.sv
package diag_seq_pkg;

	localparam int unsigned CLK_NS = 10;
	localparam int unsigned T_ONE_S_MS = 1000;
	localparam int unsigned T_TWO_S_MS = 2000;
	localparam int unsigned T_THREE_S_MS = 3000;
	localparam int unsigned T_BRIEF_MS = 250;
	localparam int unsigned T_BLINK_MS = 500;
	localparam longint ONE_S_CYC = longint'(T_ONE_S_MS) * 64'd1000000 / CLK_NS;
	localparam longint TWO_S_CYC = longint'(T_TWO_S_MS) * 64'd1000000 / CLK_NS;
	localparam longint THREE_S_CYC = longint'(T_THREE_S_MS) * 64'd1000000 / CLK_NS;
	localparam longint BRIEF_CYC = longint'(T_BRIEF_MS) * 64'd1000000 / CLK_NS;
	localparam longint BLINK_CYC = longint'(T_BLINK_MS) * 64'd1000000 / CLK_NS;

	localparam logic [3:0] DIAG_OFS = 4'h0;
	localparam logic [3:0] STATUS_OFS = 4'h4;
	localparam logic [6:0] DIAG_RESET = 7'h01;
	localparam logic [6:0] DIAG_STEP_MAX = 7'h60;
	localparam logic [6:0] DIAG_IF_HW = 7'h3e;
	localparam logic [6:0] DIAG_IF_BOTH = 7'h3f;
	localparam logic [6:0] DIAG_IF_SW = 7'h40;
	localparam logic [6:0] DIAG_IF_VERIFY = 7'h41;
	localparam logic [6:0] DIAG_KEY_TEST = 7'h46;
	localparam logic [6:0] DIAG_DISP_TEST = 7'h47;
	localparam logic [6:0] DIAG_BUS_VERIFY = 7'h50;
	localparam logic [6:0] DIAG_FILTER = 7'h61;
	localparam logic [6:0] DIAG_KB_LOCK = 7'h62;
	localparam logic [6:0] DIAG_DISP_LOCK = 7'h63;

	localparam logic [4:0] KEY_SEVEN = 5'h07;
	localparam logic [4:0] KEY_FOUR = 5'h04;
	localparam logic [4:0] KEY_ZERO = 5'h00;
	localparam logic [4:0] KEY_ENTER = 5'h0a;
	localparam logic [4:0] KEY_DIAG = 5'h0b;
	localparam logic [4:0] KEY_STEP_UP = 5'h0c;
	localparam logic [4:0] KEY_STEP_DOWN = 5'h0d;
	localparam logic [4:0] KEY_RESET = 5'h0e;
	localparam logic [4:0] KEY_SELF = 5'h0f;
	localparam logic [4:0] KEY_SCALE = 5'h10;
	localparam logic [4:0] KEY_SMOOTH = 5'h11;

	localparam logic [4:0] STEP_FIRST = 5'h01;
	localparam logic [4:0] STEP_SUPPLY = 5'h05;
	localparam logic [4:0] STEP_TIMEBASE = 5'h06;
	localparam logic [4:0] STEP_INTERP = 5'h0b;
	localparam logic [4:0] STEP_SUBSET_LAST = 5'h0d;
	localparam logic [4:0] STEP_BUS_IF = 5'h0e;
	localparam logic [4:0] STEP_PWR_LAST = 5'h11;
	localparam logic [4:0] STEP_IF_VERIFY = 5'h12;

	typedef enum logic [1:0] {RUN_POWER, RUN_SELF, RUN_SINGLE} run_type;
	typedef enum logic [3:0] {
		ST_LIT = 4'h0, ST_RUN = 4'h1, ST_MEASURE = 4'h3, ST_MSG = 4'h2,
		ST_KEYTEST = 4'h6, ST_DISPTEST = 4'h7, ST_FILTER = 4'h5,
		ST_HOLD = 4'h4, ST_PASS = 4'hc
	} state_type;
	typedef enum logic [4:0] {
		MSG_MEASURE, MSG_KEY_TEST, MSG_KEY_NAME, MSG_RESET, MSG_LOCK_KB,
		MSG_LOCK_DISP, MSG_FILTER, MSG_ADDR, MSG_FAIL, MSG_FAIL_POWER,
		MSG_FAIL_TIMEBASE, MSG_FAIL_INTERP, MSG_FAIL_SELF, MSG_PASS_SELF,
		MSG_NOT_INSTALLED, MSG_IF_VALUE, MSG_PASS, MSG_ALL_LIT, MSG_BLANK
	} msg_type;

	typedef struct packed {logic valid; logic [4:0] code;} key_type;
	typedef struct packed {
		msg_type msg; logic [6:0] arg; logic all_lit; logic annun_en; logic overload_indication_en;
	} disp_type;
	typedef struct packed {logic start; logic [4:0] id; logic mw_power_off;} test_cmd_type;
	typedef struct packed {logic done; logic pass; logic bus_if_absent;} test_ans_type;

endpackage

//--- tb/panel_model.sv
`timescale 1ns/1ps
`default_nettype none
module panel_model
	import diag_seq_pkg::*;
(
	input  wire logic         clk,
	input  wire logic         rstn,
	input  wire test_cmd_type cmd,
	input  wire logic [4:0]   fail_id,
	input  wire logic [2:0]   dly,
	output test_ans_type      ans,
	output key_type           key
);
	logic [4:0] ids_q[$];
	logic [3:0] wait_q;
	logic [4:0] cur_q;
	initial key = '0;
	// Pass and absent flags toggle between answers, done stays low, so that nothing stale is mistaken for a result.
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wait_q <= 4'h0;
			ans <= '0;
		end else begin
			ans.done <= 1'b0;
			ans.pass <= ~ans.pass;
			ans.bus_if_absent <= ~ans.bus_if_absent;
			if (cmd.start) begin
				ids_q.push_back(cmd.id);
				cur_q <= cmd.id;
				wait_q <= {1'b0, dly} + 4'h1;
			end else if (wait_q == 4'h1) begin
				ans <= {1'b1, cur_q != fail_id, cur_q == fail_id && cur_q == STEP_BUS_IF};
				wait_q <= 4'h0;
			end else if (wait_q != 4'h0) begin
				wait_q <= wait_q - 4'h1;
			end
		end
	end
	task automatic press(input logic [4:0] c);
		@(posedge clk) key <= {1'b1, c};
		@(posedge clk) key <= '0;
		repeat (4) @(posedge clk);
	endtask
endmodule
`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	import diag_seq_pkg::*;
	localparam int ONE = 20;
	localparam int THREE = 60;
	logic         clk = 1'b0;
	logic         rstn = 1'b0;
	logic         cyc = 1'b0;
	logic         stb = 1'b0;
	logic         we = 1'b0;
	logic         standby_state = 1'b0;
	logic [3:0]   adr = 4'h0;
	logic [31:0]  wdat = 32'h0;
	logic [31:0]  rdat;
	logic         ack;
	logic [4:0]   fail_id = 5'h1f;
	logic [2:0]   dly = 3'h0;
	logic [15:0]  rnd = 16'h002a;
	logic         seen_addr = 1'b0;
	logic [31:0]  q;
	logic         hw_off;
	logic         sw_off;
	key_type      key;
	test_ans_type ans;
	test_cmd_type cmd;
	disp_type     disp;
	int           n_fail = 0;
	int           n_checks = 0;
	logic [4:0]   sc_fail[5] = '{STEP_SUPPLY, STEP_TIMEBASE, STEP_INTERP, 5'h07, 5'h1f};
	msg_type      sc_msg[5] = '{MSG_FAIL_POWER, MSG_FAIL_TIMEBASE, MSG_FAIL_INTERP,
		MSG_FAIL_SELF, MSG_PASS_SELF};
	logic [4:0]   kt[4] = '{KEY_DIAG, KEY_STEP_UP, KEY_STEP_DOWN, KEY_SCALE};
	logic [4:0]   kn[4] = '{KEY_DIAG, KEY_SCALE, KEY_SMOOTH, KEY_SCALE};
	always #5 clk = ~clk;
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	always @(posedge clk) begin
		rnd <= lfsr(rnd);
		dly <= rnd[2:0];
		if (disp.msg === MSG_ADDR) seen_addr <= 1'b1;
	end
	diag_seq #(.ONE_S(32'(ONE)), .TWO_S(32'h28), .THREE_S(32'(THREE)), .BRIEF(32'h5),
		.BLINK(32'ha)) i_diag_seq (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .key(key), .standby_wake(standby_state), .ans(ans), .cmd(cmd), .disp(disp),
		.hw_if_flag_off(hw_off), .sw_if_flag_off(sw_off));
	panel_model i_panel_model (.clk(clk), .rstn(rstn), .cmd(cmd), .fail_id(fail_id),
		.dly(dly), .ans(ans), .key(key));
	task automatic print_verdict();
		if (n_fail == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_msg(input msg_type got, input msg_type exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t msg %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) begin
			n_fail++;
			print_verdict();
		end
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic wait_msg(input msg_type m, input int lim);
		int n;
		n = 0;
		while (disp.msg !== m && n < lim) begin
			@(posedge clk);
			n++;
		end
		chk_msg(disp.msg, m);
	endtask
	task automatic wait_state(input logic [3:0] s);
		int n;
		n = 0;
		q = '0;
		while (q[15:12] !== s && n < 500) begin
			wb(1'b0, STATUS_OFS, '0);
			n++;
		end
		chk(32'(q[15:12]), 32'(s));
	endtask
	// The queue of commanded steps must match a contiguous run of step numbers.
	task automatic chk_ids(input int lo, input int hi);
		chk(32'(i_panel_model.ids_q.size()), 32'(hi - lo + 1));
		foreach (i_panel_model.ids_q[i]) chk(32'(i_panel_model.ids_q[i]), 32'(lo + i));
		i_panel_model.ids_q.delete();
	endtask
	task automatic wake();
		@(posedge clk) standby_state <= 1'b1;
		@(posedge clk) standby_state <= 1'b0;
		wait_state(ST_MEASURE);
		wb(1'b0, DIAG_OFS, '0);
		chk(q, 32'h1);
		chk_ids(1, 17);
	endtask
	task automatic unlock(input logic [4:0] mid);
		i_panel_model.press(KEY_SEVEN);
		i_panel_model.press(KEY_FOUR);
		i_panel_model.press(mid);
		i_panel_model.press(KEY_RESET);
	endtask
	initial begin
		repeat (50000) @(posedge clk);
		n_fail++;
		print_verdict();
	end
	initial begin
		repeat (12) @(posedge clk);
		chk_msg(disp.msg, MSG_ALL_LIT);
		chk(32'(disp.overload_indication_en), 32'h0);
		rstn <= 1'b1;
		repeat (THREE - 3) @(posedge clk);
		chk(32'(disp.all_lit), 32'h1);
		wait_state(ST_MEASURE);
		chk(32'(seen_addr), 32'h1);
		chk_ids(1, 17);
		wb(1'b0, DIAG_OFS, '0);
		chk(q, 32'h1);
		wb(1'b0, 4'h8, '0);
		chk(q, 32'h0);
		wb(1'b1, DIAG_OFS, 32'(DIAG_DISP_TEST));
		seen_addr = 1'b0;
		for (int i = 0; i < 40; i++) begin
			@(posedge clk);
			chk(32'(disp.overload_indication_en), 32'h0);
			if (disp.msg === MSG_BLANK && disp.all_lit === 1'b0) seen_addr = 1'b1;
		end
		chk(32'(seen_addr), 32'h1);
		i_panel_model.press(KEY_RESET);
		wait_msg(MSG_MEASURE, 100);
		wb(1'b1, DIAG_OFS, 32'(DIAG_STEP_MAX));
		i_panel_model.press(KEY_STEP_UP);
		wb(1'b0, DIAG_OFS, '0);
		chk(q, 32'h60);
		wb(1'b1, DIAG_OFS, 32'(DIAG_KEY_TEST));
		wait_msg(MSG_KEY_TEST, 20);
		foreach (kt[i]) begin
			i_panel_model.press(kt[i]);
			chk_msg(disp.msg, MSG_KEY_NAME);
			chk(32'(disp.arg), 32'(kn[i]));
			wb(1'b0, STATUS_OFS, '0);
			chk(32'(q[15:12]), 32'(ST_KEYTEST));
		end
		i_panel_model.press(KEY_RESET);
		chk_msg(disp.msg, MSG_RESET);
		repeat (ONE - 10) @(posedge clk);
		chk_msg(disp.msg, MSG_RESET);
		wait_msg(MSG_MEASURE, 20);
		wb(1'b1, DIAG_OFS, 32'(DIAG_IF_BOTH));
		wait_msg(MSG_IF_VALUE, 10);
		chk(32'({hw_off, sw_off}), 32'h3);
		i_panel_model.press(KEY_RESET);
		chk(32'({hw_off, sw_off}), 32'h0);
		wb(1'b1, DIAG_OFS, 32'(DIAG_KB_LOCK));
		wait_msg(MSG_LOCK_KB, 5);
		repeat (ONE - 6) @(posedge clk);
		chk_msg(disp.msg, MSG_LOCK_KB);
		wait_msg(MSG_MEASURE, 12);
		i_panel_model.press({1'b1, rnd[3:0]});
		chk_msg(disp.msg, MSG_LOCK_KB);
		wait_msg(MSG_MEASURE, 20);
		unlock(5'h09);
		wb(1'b0, STATUS_OFS, '0);
		chk(32'(q[3]), 32'h1);
		unlock(KEY_ZERO);
		wb(1'b0, STATUS_OFS, '0);
		chk(32'(q[3]), 32'h0);
		for (int i = 0; i < 5; i++) begin
			fail_id <= sc_fail[i];
			i_panel_model.press(KEY_SELF);
			wait_msg(sc_msg[i], 300);
			if (i < 4) begin
				i_panel_model.press(KEY_RESET);
			end else begin
				repeat (THREE - 10) @(posedge clk);
				chk_msg(disp.msg, MSG_PASS_SELF);
			end
			wait_state(ST_MEASURE);
			chk_ids(5, 13);
		end
		wb(1'b1, DIAG_OFS, 32'(DIAG_IF_VERIFY));
		wait_msg(MSG_PASS, 30);
		chk(32'(cmd.mw_power_off), 32'h1);
		i_panel_model.press(KEY_RESET);
		chk(32'(cmd.mw_power_off), 32'h0);
		chk_ids(18, 18);
		fail_id <= STEP_BUS_IF;
		wb(1'b1, DIAG_OFS, 32'(DIAG_BUS_VERIFY));
		wait_msg(MSG_NOT_INSTALLED, 30);
		i_panel_model.press(KEY_RESET);
		wait_state(ST_MEASURE);
		chk_ids(14, 14);
		fail_id <= 5'h1f;
		wb(1'b1, DIAG_OFS, 32'(DIAG_FILTER));
		wait_msg(MSG_FILTER, 10);
		i_panel_model.press(KEY_RESET);
		chk_msg(disp.msg, MSG_FILTER);
		wake();
		wb(1'b1, DIAG_OFS, 32'(DIAG_DISP_LOCK));
		wait_msg(MSG_LOCK_DISP, 10);
		chk(32'({disp.annun_en, disp.overload_indication_en}), 32'h0);
		wake();
		chk_msg(disp.msg, MSG_LOCK_DISP);
		unlock(KEY_ZERO);
		wait_msg(MSG_MEASURE, 50);
		print_verdict();
	end
endmodule
`default_nettype wire
